// ---- design/tpc_read_dma.sv ----
// module: tape controller read dma path with apb registers and interrupt
`timescale 1ns/1ps
module tpc_read_dma
	import tpc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        tape_read_strobe,
	input  wire logic        tape_crc_strobe,
	input  wire logic        tape_lrc_strobe,
	input  wire logic        tape_record_pulse,
	input  wire logic [8:0]  tape_char,
	input  wire logic        tape_unit_ready,
	input  wire logic        tape_eot,
	input  wire logic        tape_error,
	output logic             tape_go,
	output logic      [2:0]  tape_function,
	output logic      [2:0]  tape_unit_sel,
	output logic      [1:0]  tape_density,
	output logic             dma_req,
	input  wire logic        dma_ack,
	input  wire logic        dma_err,
	output logic      [17:0] dma_addr,
	output logic      [15:0] dma_wdata,
	output logic             dma_hi_byte
);

	typedef struct packed {
		tpc_state_e  st;
		logic [15:0] cmd;
		logic [15:0] brc;
		logic [17:0] cma;
		logic        lrc_sel;
		logic [1:0]  irq_sts;
		logic [1:0]  irq_mask;
		logic        bus_err;
		logic        late;
		logic        pend;
		logic        last;
		logic        rec_end;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
		logic        go;
		logic        dma_req;
		logic [17:0] dma_addr;
		logic [15:0] dma_wdata;
		logic        dma_hi;
	} tpc_main_s;

	tpc_main_s  s;
	tpc_main_s  next_s;
	logic [8:0] dbuf;
	logic       seven_ch;
	logic       ev_ready;
	logic       ev_error;
	logic       wr_go;
	logic       apb_wr;
	logic       apb_rd;

	// counter step with overflow detection, shared by transfers and records
	function automatic logic [16:0] tpc_step(input logic [15:0] v);
		tpc_step = {1'b0, v} + 17'h00001;
	endfunction : tpc_step

	// address decode: high when offset names a register
	function automatic logic tpc_mapped(input logic [7:0] a);
		case (a)
			TPC_OFS_STATUS, TPC_OFS_COMMAND, TPC_OFS_BRC, TPC_OFS_CMA,
			TPC_OFS_DBUF, TPC_OFS_READ_LINES, TPC_OFS_IRQ_STS,
			TPC_OFS_IRQ_MASK: tpc_mapped = 1'b1;
			default:          tpc_mapped = 1'b0;
		endcase
	endfunction : tpc_mapped

	assign seven_ch = s.cmd[TPC_CMD_SEVEN];

	// character assembly into the data buffer
	tpc_char_assembler u_asm (
		.clk_sys          (clk_sys),
		.rst              (rst),
		.seven_ch         (seven_ch),
		.lrc_sel          (s.lrc_sel),
		.tape_read_strobe (tape_read_strobe),
		.tape_crc_strobe  (tape_crc_strobe),
		.tape_lrc_strobe  (tape_lrc_strobe),
		.tape_char        (tape_char),
		.dbuf             (dbuf)
	);

	// apb access: one wait state; writes act at the edge that sees pready high, reads are captured at the edge that sees it low
	assign apb_wr = psel && penable && s.pready && pwrite && tpc_mapped(paddr);
	assign apb_rd = psel && penable && !s.pready && !pwrite;
	assign wr_go  = apb_wr && (paddr == TPC_OFS_COMMAND) && pwdata[TPC_CMD_GO];

	// next-state logic
	always_comb
	begin
		logic [16:0] bstep;
		logic [31:0] rd;
		bstep     = tpc_step(s.brc);
		rd        = 32'h00000000;
		next_s    = s;
		ev_ready  = 1'b0;
		ev_error  = 1'b0;
		next_s.go = 1'b0;

		// bus handshake
		next_s.pready  = psel && penable && !s.pready;
		next_s.pslverr = psel && penable && !s.pready && !tpc_mapped(paddr);

		// register reads
		case (paddr)
			TPC_OFS_STATUS:
			begin
				rd[TPC_ST_UNIT_RDY] = tape_unit_ready;
				rd[TPC_ST_EOT]      = tape_eot;
				rd[TPC_ST_BUS_ERR]  = s.bus_err;
				rd[TPC_ST_LATE]     = s.late;
				rd[TPC_ST_TAPE_ERR] = tape_error;
				rd[TPC_ST_CU_RDY]   = (s.st == TPC_ST_READY);
			end
			TPC_OFS_COMMAND:
			begin
				rd[15:0]           = s.cmd;
				rd[TPC_CMD_READY]  = (s.st == TPC_ST_READY);
				rd[TPC_CMD_ERR]    = s.bus_err || s.late || tape_error;
			end
			TPC_OFS_BRC:        rd[15:0] = s.brc;
			TPC_OFS_CMA:        rd[17:0] = s.cma;
			TPC_OFS_DBUF:       rd[8:0]  = dbuf;
			TPC_OFS_READ_LINES:
			begin
				rd[TPC_RL_LRC_SEL] = s.lrc_sel;
				rd[8:0]            = tape_char;
			end
			TPC_OFS_IRQ_STS:    rd[1:0] = s.irq_sts;
			TPC_OFS_IRQ_MASK:   rd[1:0] = s.irq_mask;
			default:            rd = 32'h00000000;
		endcase
		// read data stands only with pready; other answers carry zero
		next_s.prdata = apb_rd ? rd : 32'h00000000;

		// register writes; counters only loaded while idle
		if (apb_wr)
		begin
			case (paddr)
				TPC_OFS_COMMAND:
					next_s.cmd = pwdata[15:0] & TPC_CMD_WMASK;
				TPC_OFS_BRC:
					if (s.st == TPC_ST_READY)
						next_s.brc = pwdata[15:0];
				TPC_OFS_CMA:
					if (s.st == TPC_ST_READY)
						next_s.cma = pwdata[17:0];
				TPC_OFS_READ_LINES:
					next_s.lrc_sel = pwdata[TPC_RL_LRC_SEL];
				TPC_OFS_IRQ_MASK:
					next_s.irq_mask = pwdata[1:0];
				default:
					next_s.cmd = s.cmd;
			endcase
		end

		// function sequencing
		case (s.st)
			TPC_ST_READY:
			begin
				next_s.pend    = 1'b0;
				next_s.last    = 1'b0;
				next_s.rec_end = 1'b0;
				if (wr_go)
				begin
					next_s.go      = 1'b1;
					next_s.bus_err = 1'b0;
					next_s.late    = 1'b0;
					case (pwdata[TPC_CMD_FN_LO +: 3])
						TPC_FN_READ:      next_s.st = TPC_ST_READ;
						TPC_FN_SPACE_FWD: next_s.st = TPC_ST_SPACE;
						TPC_FN_SPACE_REV: next_s.st = TPC_ST_SPACE;
						default:          next_s.st = TPC_ST_READY;
					endcase
				end
			end
			TPC_ST_READ:
			begin
				if (tape_record_pulse)
					next_s.rec_end = 1'b1;
				// a strobe after the final transfer raises nothing
				if (tape_read_strobe && !s.last)
				begin
					if (s.pend)
					begin
						next_s.late = 1'b1;
						ev_error    = 1'b1;
						next_s.st   = TPC_ST_READY;
					end
					else
						next_s.pend = 1'b1;
				end
				// request once the buffer has taken the character
				if (s.pend && !s.dma_req && !s.last)
				begin
					next_s.dma_req   = 1'b1;
					next_s.dma_addr  = s.cma;
					next_s.dma_wdata = {dbuf[7:0], dbuf[7:0]};
					next_s.dma_hi    = s.cma[0];
				end
				if (s.dma_req && dma_err)
				begin
					next_s.dma_req = 1'b0;
					next_s.bus_err = 1'b1;
					ev_error       = 1'b1;
					next_s.st      = TPC_ST_READY;
				end
				else if (s.dma_req && dma_ack)
				begin
					next_s.dma_req = 1'b0;
					next_s.pend    = 1'b0;
					next_s.cma     = s.cma + 18'h00001;
					next_s.brc     = bstep[15:0];
					if (bstep[16])
					begin
						next_s.last = 1'b1;
						next_s.st   = TPC_ST_READY;
					end
				end
				if (s.rec_end && !s.pend && !s.dma_req)
					next_s.st = TPC_ST_READY;
				if (tape_error)
				begin
					ev_error  = 1'b1;
					next_s.st = TPC_ST_READY;
				end
			end
			TPC_ST_SPACE:
			begin
				if (tape_record_pulse)
				begin
					next_s.brc = bstep[15:0];
					if (bstep[16])
						next_s.st = TPC_ST_READY;
				end
				if (tape_error || tape_eot)
				begin
					ev_error  = tape_error;
					next_s.st = TPC_ST_READY;
				end
			end
			default:
				next_s.st = TPC_ST_READY;
		endcase

		// any return to the ready state drops the request line
		if (next_s.st == TPC_ST_READY)
			next_s.dma_req = 1'b0;

		ev_ready = (s.st != TPC_ST_READY) && (next_s.st == TPC_ST_READY);

		// sticky interrupt bits: write one clears, a new event wins
		if (apb_wr && paddr == TPC_OFS_IRQ_STS)
			next_s.irq_sts = s.irq_sts & ~pwdata[1:0];
		if (ev_ready)
			next_s.irq_sts[TPC_IRQ_READY] = 1'b1;
		if (ev_error)
			next_s.irq_sts[TPC_IRQ_ERROR] = 1'b1;

		// interrupt gated by mask and command enable
		next_s.irq = |(next_s.irq_sts & next_s.irq_mask)
			&& next_s.cmd[TPC_CMD_IRQ_EN];
	end

	// state register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s          <= '0;
			s.st       <= TPC_ST_READY;
			s.cmd      <= TPC_RST_CMD;
			s.brc      <= TPC_RST_BRC;
			s.cma      <= TPC_RST_CMA;
			s.irq_mask <= TPC_RST_MASK;
		end
		else
			s <= next_s;
	end

	// outputs straight from state flops
	assign prdata        = s.prdata;
	assign pready        = s.pready;
	assign pslverr       = s.pslverr;
	assign irq           = s.irq;
	assign tape_go       = s.go;
	assign tape_function = s.cmd[TPC_CMD_FN_LO +: 3];
	assign tape_unit_sel = s.cmd[TPC_CMD_SEL_LO +: 3];
	assign tape_density  = s.cmd[TPC_CMD_DEN_LO +: 2];
	assign dma_req       = s.dma_req;
	assign dma_addr      = s.dma_addr;
	assign dma_wdata     = s.dma_wdata;
	assign dma_hi_byte   = s.dma_hi;

endmodule : tpc_read_dma

// ---- design/tpc_pkg.sv ----
// package: register map, field positions, reset values and states of the tape read dma path
package tpc_pkg;

	// register byte offsets
	localparam logic [7:0] TPC_OFS_STATUS    = 8'h00;
	localparam logic [7:0] TPC_OFS_COMMAND   = 8'h04;
	localparam logic [7:0] TPC_OFS_BRC       = 8'h08;
	localparam logic [7:0] TPC_OFS_CMA       = 8'h0C;
	localparam logic [7:0] TPC_OFS_DBUF      = 8'h10;
	localparam logic [7:0] TPC_OFS_READ_LINES = 8'h14;
	localparam logic [7:0] TPC_OFS_IRQ_STS   = 8'h18;
	localparam logic [7:0] TPC_OFS_IRQ_MASK  = 8'h1C;

	// command register fields
	localparam int TPC_CMD_GO      = 0;
	localparam int TPC_CMD_FN_LO   = 1;
	localparam int TPC_CMD_IRQ_EN  = 6;
	localparam int TPC_CMD_READY   = 7;
	localparam int TPC_CMD_SEL_LO  = 8;
	localparam int TPC_CMD_SEVEN   = 11;
	localparam int TPC_CMD_DEN_LO  = 13;
	localparam int TPC_CMD_ERR     = 15;
	localparam logic [15:0] TPC_CMD_WMASK = 16'h6F4E;

	// function codes
	localparam logic [2:0] TPC_FN_READ      = 3'h1;
	localparam logic [2:0] TPC_FN_SPACE_FWD = 3'h2;
	localparam logic [2:0] TPC_FN_SPACE_REV = 3'h3;

	// read lines register: end-of-record select bit
	localparam int TPC_RL_LRC_SEL = 14;

	// status register fields
	localparam int TPC_ST_UNIT_RDY = 0;
	localparam int TPC_ST_EOT      = 1;
	localparam int TPC_ST_BUS_ERR  = 2;
	localparam int TPC_ST_LATE     = 3;
	localparam int TPC_ST_TAPE_ERR = 4;
	localparam int TPC_ST_CU_RDY   = 5;

	// interrupt status bits
	localparam int TPC_IRQ_READY = 0;
	localparam int TPC_IRQ_ERROR = 1;

	// reset values
	localparam logic [15:0] TPC_RST_CMD  = 16'h0000;
	localparam logic [15:0] TPC_RST_BRC  = 16'h0000;
	localparam logic [17:0] TPC_RST_CMA  = 18'h00000;
	localparam logic [1:0]  TPC_RST_MASK = 2'h0;

	typedef enum logic [1:0] {
		TPC_ST_READY,
		TPC_ST_READ,
		TPC_ST_SPACE
	} tpc_state_e;

endpackage : tpc_pkg

// ---- design/tpc_char_assembler.sv ----
// module: assembles tape characters into the data buffer
`timescale 1ns/1ps
module tpc_char_assembler
	import tpc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       seven_ch,
	input  wire logic       lrc_sel,
	input  wire logic       tape_read_strobe,
	input  wire logic       tape_crc_strobe,
	input  wire logic       tape_lrc_strobe,
	input  wire logic [8:0] tape_char,
	output logic      [8:0] dbuf
);

	typedef struct packed {
		logic [8:0] dbuf;
	} tpc_asm_s;

	tpc_asm_s s;
	tpc_asm_s next_s;

	// choose what lands in the buffer; bit 8 carries parity
	always_comb
	begin
		next_s = s;
		if (tape_read_strobe)
		begin
			if (seven_ch)
				next_s.dbuf = {tape_char[8], 2'b00, tape_char[5:0]};
			else
				next_s.dbuf = tape_char;
		end
		else if (!seven_ch && tape_crc_strobe && !lrc_sel)
			next_s.dbuf = tape_char;
		else if (!seven_ch && tape_lrc_strobe && lrc_sel)
			next_s.dbuf = tape_char;
		else if (seven_ch && tape_lrc_strobe && lrc_sel)
			next_s.dbuf = {tape_char[8], 2'b00, tape_char[5:0]};
	end

	// state register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign dbuf = s.dbuf;

endmodule : tpc_char_assembler

// ---- verif/tpc_read_dma_monitor.sv ----
// checker: port timing of the tape read dma path
`timescale 1ns/1ps
module tpc_read_dma_monitor(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        tape_read_strobe,
	input wire logic        tape_go,
	input wire logic        dma_req,
	input wire logic        dma_ack,
	input wire logic        dma_err,
	input wire logic [17:0] dma_addr,
	input wire logic [15:0] dma_wdata,
	input wire logic        dma_hi_byte
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// dma request and its address hold until answered
	a_req_hold: assert property
		(dma_req && !dma_ack && !dma_err |=> dma_req && $stable(dma_addr))
		else $error("dma request changed before answer");
	a_req_drop: assert property
		(dma_req && (dma_ack || dma_err) |=> !dma_req)
		else $error("dma request still up after answer");
	a_byte_lane: assert property
		(dma_req |-> dma_hi_byte == dma_addr[0])
		else $error("byte lane does not follow address");
	a_byte_copy: assert property
		(dma_req |-> dma_wdata[15:8] == dma_wdata[7:0])
		else $error("byte lanes differ");
	a_req_start: assert property
		($rose(dma_req) |-> $past(tape_read_strobe, 2))
		else $error("dma request without read strobe");
	// register bus answer timing
	a_apb_wait: assert property
		(psel && penable && !pready |=> pready)
		else $error("no answer after one wait state");
	a_apb_single: assert property
		(pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_empty: assert property
		(pready && pslverr |-> prdata == 32'h0)
		else $error("error answer carries data");
	a_go_pulse: assert property
		(tape_go |=> !tape_go)
		else $error("go longer than one cycle");
endmodule : tpc_read_dma_monitor
bind tpc_read_dma tpc_read_dma_monitor mon (
	.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .tape_read_strobe(tape_read_strobe),
	.tape_go(tape_go), .dma_req(dma_req), .dma_ack(dma_ack), .dma_err(dma_err),
	.dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_hi_byte(dma_hi_byte)
);

// ---- verif/tpc_host_mem.sv ----
// partner: host memory answering dma byte writes
`timescale 1ns/1ps
module tpc_host_mem(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        dma_req,
	input wire logic        dma_hi_byte,
	input wire logic        slow,
	input wire logic        fail,
	input wire logic [17:0] dma_addr,
	input wire logic [15:0] dma_wdata,
	output logic            dma_ack,
	output logic            dma_err
);
	logic [7:0] mem [0:63];
	logic [3:0] wait_n;
	// answer each byte write after a short or long wait
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			dma_ack <= 1'b0;
			dma_err <= 1'b0;
			wait_n <= 4'h0;
		end
		else
		begin
			dma_ack <= 1'b0;
			dma_err <= 1'b0;
			if (dma_req && !dma_ack && !dma_err)
			begin
				wait_n <= wait_n + 4'h1;
				if (wait_n >= (slow ? 4'h5 : 4'h0))
				begin
					wait_n <= 4'h0;
					dma_err <= fail;
					dma_ack <= !fail;
					if (!fail)
						mem[dma_addr[5:0]] <= dma_hi_byte ? dma_wdata[15:8] : dma_wdata[7:0];
				end
			end
		end
	end
endmodule : tpc_host_mem

// ---- verif/tpc_read_dma_bench.sv ----
// bench: scenarios for the tape read dma path
`timescale 1ns/1ps
`define CHK(g,e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tpc_read_dma_bench;
	logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic        pready, pslverr, irq, qe, tape_go, dma_req, dma_ack, dma_err, dma_hi_byte;
	logic        tape_read_strobe = 0, tape_crc_strobe = 0, tape_lrc_strobe = 0;
	logic        tape_record_pulse = 0, tape_unit_ready = 1, tape_eot = 0, tape_error = 0;
	logic        slow = 0, fail = 0;
	logic [8:0]  tape_char = 0;
	logic [2:0]  tape_function, tape_unit_sel;
	logic [1:0]  tape_density;
	logic [17:0] dma_addr;
	logic [15:0] dma_wdata;
	int          bad_count = 0, n_compared = 0;
	tpc_read_dma dut (
		.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .tape_read_strobe(tape_read_strobe), .tape_crc_strobe(tape_crc_strobe),
		.tape_lrc_strobe(tape_lrc_strobe), .tape_record_pulse(tape_record_pulse),
		.tape_char(tape_char), .tape_unit_ready(tape_unit_ready), .tape_eot(tape_eot),
		.tape_error(tape_error), .tape_go(tape_go), .tape_function(tape_function),
		.tape_unit_sel(tape_unit_sel), .tape_density(tape_density), .dma_req(dma_req),
		.dma_ack(dma_ack), .dma_err(dma_err), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
		.dma_hi_byte(dma_hi_byte)
	);
	tpc_host_mem hm (
		.clk_sys(clk_sys), .rst(rst), .dma_req(dma_req), .dma_hi_byte(dma_hi_byte),
		.slow(slow), .fail(fail), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
		.dma_ack(dma_ack), .dma_err(dma_err)
	);
	// 25 MHz system clock
	always #20 clk_sys = ~clk_sys;
	task tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	// one register transfer, then one idle cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1 && ++i < 20);
		q = prdata;
		qe = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 20) begin bad_count++; tally_and_finish; end
		@(posedge clk_sys);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask : rd
	// one transport strobe; a data strobe waits for the host answer
	task automatic pulse(input logic [3:0] s, input logic [8:0] c);
		int i = 0;
		tape_char <= c;
		{tape_record_pulse, tape_lrc_strobe, tape_crc_strobe, tape_read_strobe} <= s;
		@(posedge clk_sys);
		{tape_record_pulse, tape_lrc_strobe, tape_crc_strobe, tape_read_strobe} <= 4'h0;
		do @(posedge clk_sys); while (s[0] && !(dma_ack | dma_err) && ++i < 40);
		if (i >= 40) begin bad_count++; tally_and_finish; end
	endtask : pulse
	task automatic run_reset;
		rd(8'h00, 32'h21);
		rd(8'h08, 32'h0);
		rd(8'h0C, 32'h0);
		rd(8'h20, 32'h0);
		`CHK(qe, 1'b1)
		$display("test reset done");
	endtask : run_reset
	task automatic run_final;
		apb(1'b1, 8'h1C, 32'h3);
		apb(1'b1, 8'h08, 32'hFFFE);
		apb(1'b1, 8'h0C, 32'h10);
		apb(1'b1, 8'h04, 32'h43);
		pulse(4'h1, 9'h1A5);
		pulse(4'h1, 9'h13C);
		tape_read_strobe <= 1'b1;
		@(posedge clk_sys);
		tape_read_strobe <= 1'b0;
		repeat (8) @(posedge clk_sys) `CHK(dma_req, 1'b0)
		`CHK(hm.mem[16], 8'hA5)
		`CHK(hm.mem[17], 8'h3C)
		rd(8'h0C, 32'h12);
		rd(8'h08, 32'h0);
		rd(8'h04, 32'hC2);
		rd(8'h18, 32'h1);
		`CHK(irq, 1'b1)
		apb(1'b1, 8'h04, 32'h0);
		rd(8'h18, 32'h1);
		`CHK(irq, 1'b0)
		apb(1'b1, 8'h18, 32'h1);
		rd(8'h18, 32'h0);
		$display("test final transfer done");
	endtask : run_final
	task automatic run_fault;
		fail <= 1'b1;
		apb(1'b1, 8'h08, 32'hFFFC);
		apb(1'b1, 8'h0C, 32'h30);
		apb(1'b1, 8'h04, 32'h43);
		pulse(4'h1, 9'h055);
		fail <= 1'b0;
		rd(8'h0C, 32'h30);
		rd(8'h00, 32'h25);
		rd(8'h18, 32'h3);
		`CHK(irq, 1'b1)
		apb(1'b1, 8'h18, 32'h3);
		$display("test bus fault done");
	endtask : run_fault
	// a second strobe while a byte is pending, then a space cut by end of tape
	task automatic run_late;
		apb(1'b1, 8'h08, 32'hFFF0);
		apb(1'b1, 8'h04, 32'h43);
		tape_char <= 9'h012;
		tape_read_strobe <= 1'b1;
		repeat (2) @(posedge clk_sys);
		tape_read_strobe <= 1'b0;
		repeat (2) @(posedge clk_sys);
		`CHK(dma_req, 1'b0)
		rd(8'h00, 32'h29);
		rd(8'h04, 32'h80C2);
		rd(8'h18, 32'h3);
		apb(1'b1, 8'h18, 32'h3);
		apb(1'b1, 8'h04, 32'h05);
		tape_eot <= 1'b1;
		@(posedge clk_sys);
		rd(8'h00, 32'h23);
		tape_eot <= 1'b0;
		rd(8'h18, 32'h1);
		apb(1'b1, 8'h18, 32'h1);
		$display("test late strobe done");
	endtask : run_late
	task automatic run_space(input logic [2:0] fn);
		apb(1'b1, 8'h08, 32'hFFFE);
		apb(1'b1, 8'h04, 32'h4501 | {28'h0, fn, 1'b0});
		`CHK(tape_function, fn)
		`CHK(tape_unit_sel, 3'h5)
		`CHK(tape_density, 2'h2)
		pulse(4'h8, 9'h0);
		rd(8'h08, 32'hFFFF);
		pulse(4'h8, 9'h0);
		rd(8'h08, 32'h0);
		rd(8'h00, 32'h21);
		`CHK(irq, 1'b0)
		$display("test space done");
	endtask : run_space
	task automatic run_rec(input logic [15:0] c, input logic s, input logic [8:0] d,
		input logic [7:0] m, input logic [7:0] b);
		apb(1'b1, 8'h14, {17'h0, s, 14'h0});
		apb(1'b1, 8'h08, 32'hFFF8);
		apb(1'b1, 8'h0C, 32'h21);
		apb(1'b1, 8'h04, {16'h0, c});
		pulse(4'h1, d);
		pulse(4'h2, 9'h0C3);
		pulse(4'h4, 9'h11A);
		pulse(4'h8, 9'h0);
		`CHK(hm.mem[33], m)
		apb(1'b0, 8'h10, 32'h0);
		`CHK(q[7:0], b)
		rd(8'h0C, 32'h22);
		rd(8'h08, 32'hFFF9);
		$display("test record done");
	endtask : run_rec
	// reset, then the scenarios in turn
	initial
	begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		run_reset;
		run_final;
		run_fault;
		run_late;
		run_space(3'h2);
		run_space(3'h3);
		run_rec(16'h0003, 1'b0, 9'h1E7, 8'hE7, 8'hC3);
		run_rec(16'h0003, 1'b1, 9'h1E7, 8'hE7, 8'h1A);
		slow <= 1'b1;
		run_rec(16'h0803, 1'b1, 9'h1FF, 8'h3F, 8'h1A);
		run_rec(16'h0803, 1'b0, 9'h1FF, 8'h3F, 8'h3F);
		tally_and_finish;
	end
endmodule : tpc_read_dma_bench
